// ### logic/pdev_consts.svh
// Constants for the PD MAC event-status block: register indices, bit positions and reset values.
// Assumes inclusion by bare name from the package and the design file.
`ifndef PDEV_CONSTS_SVH
`define PDEV_CONSTS_SVH

// Register indices; byte address is four times the index
`define PDEV_IDX_SUMMARY 16'h1A80
`define PDEV_IDX_TX_STAT 16'h1A81
`define PDEV_IDX_RX_STAT 16'h1A82
`define PDEV_IDX_TX_EN 16'h1A89
`define PDEV_IDX_RX_EN 16'h1A8A
`define PDEV_IDX_MODE 16'h1A90
`define PDEV_IDX_RX_CTL_SECOND 16'h1A91

// Transmit event bits
`define PDEV_TX_ACKED 0
`define PDEV_TX_FAILED 1
`define PDEV_TX_END 3

// Receive event bits
`define PDEV_RX_MSG 0
`define PDEV_VALID_START_FRAMING_SEEN 1
`define PDEV_VALID_END_FRAMING_SEEN 2
`define PDEV_RX_HARD_RST 3
`define PDEV_RX_RESERVED 4
`define PDEV_RX_CABLE_RST 5
`define PDEV_RX_IDLE 6
`define PDEV_RX_FIFO 7

// Summary bits
`define PDEV_SUM_TX 0
`define PDEV_SUM_RX 1

// Mode register bits
`define PDEV_MODE_RETRY 0
`define PDEV_MODE_RESPONSE 1
`define PDEV_MODE_ACK_TMR 2

// Masks of implemented bits and reset values
`define PDEV_TX_W1C_MASK 8'h0B
`define PDEV_RX_W1C_MASK 8'h6F
`define PDEV_TX_STAT_RESET 8'h00
`define PDEV_RX_STAT_RESET 8'h40
`define PDEV_EN_RESET 8'h00
`define PDEV_MODE_RESET 3'h0
`define PDEV_SOP_EN_RESET 5'h00

`endif

// ### logic/pdev_pkg.sv
// Types shared by the PD MAC event-status block and its bench.
// Assumes the constants header sits beside it.
`include "pdev_consts.svh"

package pdev_pkg;
  typedef logic [15:0] pdev_addr_t;
  typedef logic [31:0] pdev_word_t;
  typedef logic [7:0] pdev_byte_t;
  typedef logic [2:0] pdev_sop_type_t;
  typedef enum logic {PDEV_BUS_IDLE, PDEV_BUS_ANSWER} pdev_bus_state_t;
endpackage : pdev_pkg

// ### logic/pdev_event_status.sv
// Transmit and receive event-status registers of a PD MAC, with enables and summary.
// Assumes event strobes come from datapath logic on clk; the line activity input is a pin.
//
// Our own choice: the Avalon-MM interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "pdev_consts.svh"

module pdev_event_status (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  // Avalon-MM slave
  input wire pdev_pkg::pdev_addr_t address,
  input wire logic read,
  input wire logic write,
  input wire logic [3:0] byteenable,
  input wire pdev_pkg::pdev_word_t writedata,
  output pdev_pkg::pdev_word_t readdata,
  output logic waitrequest,
  // Transmitter events
  input wire logic ack_timer_expired,
  input wire logic retry_limit_exceeded,
  input wire logic goodcrc_reply_seen,
  input wire logic tx_is_reset_signal,
  input wire logic tx_switched_off,
  // Receiver events
  input wire logic rx_fifo_has_data,
  input wire logic line_activity_pin,
  input wire logic rx_cable_reset,
  input wire logic rx_hard_reset,
  input wire logic valid_start_framing_seen_ok,
  input wire logic valid_end_framing_seen_ok,
  input wire logic valid_end_framing_seen_bad,
  input wire pdev_pkg::pdev_sop_type_t valid_start_framing_seen_type,
  input wire logic rx_msg_ok,
  input wire logic rx_msg_is_goodcrc,
  input wire logic rx_msg_is_duplicate,
  // Controls toward the datapaths
  output logic auto_retry_mode,
  output logic auto_response_mode,
  output logic ack_timer_enable,
  output logic [4:0] receive_control_second,
  output logic rx_discard,
  // Interrupt request lines
  output logic tx_event_irq,
  output logic rx_event_irq
);
  import pdev_pkg::*;

  pdev_bus_state_t bus_state;
  pdev_byte_t tx_stat;
  pdev_byte_t rx_stat;
  pdev_byte_t tx_en;
  pdev_byte_t rx_en;
  pdev_byte_t next_tx_set;
  pdev_byte_t next_rx_set;
  pdev_byte_t tx_clr;
  pdev_byte_t rx_clr;
  pdev_byte_t rx_view;
  pdev_byte_t summary;
  pdev_byte_t read_byte;
  logic sync_a;
  logic sync_b;
  logic sync_c;
  logic line_busy;
  logic line_went_quiet;
  logic idle_enable_rise;
  logic take;
  logic wr_low;
  logic sop_type_enabled;
  logic frame_open;
  logic msg_kept;

  // Register hit helper: byte address is four times the index
  function automatic logic hit(input pdev_addr_t addr, input logic [15:0] idx);
    hit = (addr == {idx[13:0], 2'b00});
  endfunction : hit

  // Bus handshake: the request is taken on the edge that sees waitrequest low
  assign take = ce && (read || write) && (bus_state == PDEV_BUS_ANSWER);
  assign wr_low = take && write && byteenable[0];

  // Answer one cycle after the request is seen, then release for one cycle
  always_ff @(posedge clk) begin
    if (!rstn) begin
      bus_state <= PDEV_BUS_IDLE;
      waitrequest <= 1'b1;
    end else if (ce) begin
      case (bus_state)
        PDEV_BUS_IDLE: begin
          if (read || write) begin
            bus_state <= PDEV_BUS_ANSWER;
            waitrequest <= 1'b0;
          end
        end
        PDEV_BUS_ANSWER: begin
          bus_state <= PDEV_BUS_IDLE;
          waitrequest <= 1'b1;
        end
        default: begin
          bus_state <= PDEV_BUS_IDLE;
          waitrequest <= 1'b1;
        end
      endcase
    end
  end

  // Line activity pin: three stages, a change counts once the last two agree
  always_ff @(posedge clk) begin
    if (!rstn) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
      sync_c <= 1'b0;
      line_busy <= 1'b0;
    end else if (ce) begin
      sync_a <= line_activity_pin;
      sync_b <= sync_a;
      sync_c <= sync_b;
      if (sync_b == sync_c) begin
        line_busy <= sync_c;
      end
    end
  end

  // Idle edge and enable edge; both need clock, so a held clock reports nothing
  assign line_went_quiet = line_busy && (sync_b == sync_c) && !sync_c;
  assign idle_enable_rise = wr_low && hit(address, `PDEV_IDX_RX_EN)
                            && writedata[`PDEV_RX_IDLE] && !rx_en[`PDEV_RX_IDLE]
                            && !line_busy;

  // SOP type filter for start and end framing
  assign sop_type_enabled = (valid_start_framing_seen_type < 3'h5) && receive_control_second[valid_start_framing_seen_type];

  // Remember whether the open frame began with an enabled SOP type
  always_ff @(posedge clk) begin
    if (!rstn) begin
      frame_open <= 1'b0;
    end else if (ce) begin
      if (valid_start_framing_seen_ok) begin
        frame_open <= sop_type_enabled;
      end else if (valid_end_framing_seen_ok || valid_end_framing_seen_bad) begin
        frame_open <= 1'b0;
      end
    end
  end

  // Messages that the modes swallow never reach the message flag
  assign msg_kept = rx_msg_ok
                    && !(auto_retry_mode && rx_msg_is_goodcrc)
                    && !(auto_response_mode && rx_msg_is_duplicate);

  // Hardware set terms of the transmit flags
  always_comb begin
    next_tx_set = 8'h00;
    next_tx_set[`PDEV_TX_FAILED] = (auto_retry_mode || ack_timer_enable)
                                   && (ack_timer_expired || retry_limit_exceeded);
    next_tx_set[`PDEV_TX_ACKED] = auto_retry_mode && goodcrc_reply_seen
                                  && !tx_is_reset_signal;
    next_tx_set[`PDEV_TX_END] = tx_switched_off;
  end

  // Hardware set terms of the receive flags
  always_comb begin
    next_rx_set = 8'h00;
    next_rx_set[`PDEV_RX_IDLE] = line_went_quiet || idle_enable_rise;
    next_rx_set[`PDEV_RX_CABLE_RST] = rx_cable_reset;
    next_rx_set[`PDEV_RX_HARD_RST] = rx_hard_reset;
    next_rx_set[`PDEV_VALID_END_FRAMING_SEEN] = valid_end_framing_seen_ok && frame_open;
    next_rx_set[`PDEV_VALID_START_FRAMING_SEEN] = valid_start_framing_seen_ok && sop_type_enabled;
    // Set on acceptance, ahead of any automatic GoodCRC reply
    next_rx_set[`PDEV_RX_MSG] = msg_kept;
  end

  // Write-one-to-clear masks; zero bits clear nothing
  assign tx_clr = (wr_low && hit(address, `PDEV_IDX_TX_STAT))
                  ? (writedata[7:0] & `PDEV_TX_W1C_MASK) : 8'h00;
  assign rx_clr = (wr_low && hit(address, `PDEV_IDX_RX_STAT))
                  ? (writedata[7:0] & `PDEV_RX_W1C_MASK) : 8'h00;

  // Transmit flags: set wins over a clear in the same cycle
  always_ff @(posedge clk) begin
    if (!rstn) begin
      tx_stat <= `PDEV_TX_STAT_RESET;
    end else if (ce) begin
      tx_stat <= ((tx_stat & ~tx_clr) | next_tx_set) & `PDEV_TX_W1C_MASK;
    end
  end

  // Receive flags: set wins over a clear in the same cycle
  always_ff @(posedge clk) begin
    if (!rstn) begin
      rx_stat <= `PDEV_RX_STAT_RESET;
    end else if (ce) begin
      rx_stat <= ((rx_stat & ~rx_clr) | next_rx_set) & `PDEV_RX_W1C_MASK;
    end
  end

  // Live FIFO bit and zero reserved bit merged into the receive view
  always_comb begin
    rx_view = rx_stat;
    rx_view[`PDEV_RX_FIFO] = rx_fifo_has_data;
    rx_view[`PDEV_RX_RESERVED] = 1'b0;
  end

  // Summary is derived, never stored, so it cannot drift from its sources
  always_comb begin
    summary = 8'h00;
    summary[`PDEV_SUM_TX] = |(tx_stat & tx_en);
    summary[`PDEV_SUM_RX] = |(rx_view & rx_en);
  end

  // Enable registers
  always_ff @(posedge clk) begin
    if (!rstn) begin
      tx_en <= `PDEV_EN_RESET;
      rx_en <= `PDEV_EN_RESET;
    end else if (ce && wr_low) begin
      if (hit(address, `PDEV_IDX_TX_EN)) begin
        tx_en <= writedata[7:0];
      end else if (hit(address, `PDEV_IDX_RX_EN)) begin
        rx_en <= writedata[7:0];
      end
    end
  end

  // Mode and SOP-type enables that steer the datapaths and this block
  always_ff @(posedge clk) begin
    if (!rstn) begin
      auto_retry_mode <= `PDEV_MODE_RESET == 3'h7;
      auto_response_mode <= 1'b0;
      ack_timer_enable <= 1'b0;
      receive_control_second <= `PDEV_SOP_EN_RESET;
    end else if (ce && wr_low) begin
      if (hit(address, `PDEV_IDX_MODE)) begin
        auto_retry_mode <= writedata[`PDEV_MODE_RETRY];
        auto_response_mode <= writedata[`PDEV_MODE_RESPONSE];
        ack_timer_enable <= writedata[`PDEV_MODE_ACK_TMR];
      end else if (hit(address, `PDEV_IDX_RX_CTL_SECOND)) begin
        receive_control_second <= writedata[4:0];
      end
    end
  end

  // Read multiplexer; unmapped addresses read as zero
  always_comb begin
    read_byte = 8'h00;
    if (hit(address, `PDEV_IDX_SUMMARY)) begin
      read_byte = summary;
    end else if (hit(address, `PDEV_IDX_TX_STAT)) begin
      read_byte = tx_stat;
    end else if (hit(address, `PDEV_IDX_RX_STAT)) begin
      read_byte = rx_view;
    end else if (hit(address, `PDEV_IDX_TX_EN)) begin
      read_byte = tx_en;
    end else if (hit(address, `PDEV_IDX_RX_EN)) begin
      read_byte = rx_en;
    end else if (hit(address, `PDEV_IDX_MODE)) begin
      read_byte = {5'h00, ack_timer_enable, auto_response_mode, auto_retry_mode};
    end else if (hit(address, `PDEV_IDX_RX_CTL_SECOND)) begin
      read_byte = {3'h0, receive_control_second};
    end
  end

  // Read data is loaded as waitrequest drops, so it stands on the taking edge
  always_ff @(posedge clk) begin
    if (!rstn) begin
      readdata <= 32'h00000000;
    end else if (ce && (bus_state == PDEV_BUS_IDLE) && read) begin
      readdata <= {24'h000000, read_byte};
    end
  end

  // Discard strobe for dropped packets, one cycle per event
  always_ff @(posedge clk) begin
    if (!rstn) begin
      rx_discard <= 1'b0;
    end else if (ce) begin
      rx_discard <= valid_end_framing_seen_bad || (rx_msg_ok && !msg_kept);
    end
  end

  // Interrupt lines follow the summary a cycle later
  always_ff @(posedge clk) begin
    if (!rstn) begin
      tx_event_irq <= 1'b0;
      rx_event_irq <= 1'b0;
    end else if (ce) begin
      tx_event_irq <= summary[`PDEV_SUM_TX];
      rx_event_irq <= summary[`PDEV_SUM_RX];
    end
  end
endmodule : pdev_event_status
`default_nettype wire

// ### verif/pdev_event_status_properties.sv
// Checker for the bus handshake, the discard pulse and register read-back.
// Assumes binding to the event-status top; it sees only that module's ports.
`timescale 1ns/1ns
`default_nettype none
`include "pdev_consts.svh"
module pdev_chk (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  // Bus
  input wire pdev_pkg::pdev_addr_t address,
  input wire logic read,
  input wire logic write,
  input wire pdev_pkg::pdev_word_t readdata,
  input wire logic waitrequest,
  // Receive events
  input wire logic rx_fifo_has_data,
  input wire logic valid_end_framing_seen_bad,
  input wire logic rx_msg_ok,
  input wire logic rx_msg_is_goodcrc,
  input wire logic rx_msg_is_duplicate,
  // Outputs
  input wire logic auto_retry_mode,
  input wire logic auto_response_mode,
  input wire logic [4:0] receive_control_second,
  input wire logic rx_discard,
  input wire logic rx_event_irq,
  input wire logic tx_event_irq
);
  import pdev_pkg::*;
  logic cause_q;
  logic take_q;
  logic rx_rd;
  // Modes are sampled with the message, as the block sees them
  always_ff @(posedge clk) begin
    if (!rstn) begin
      cause_q <= 1'b0;
      take_q <= 1'b0;
    end else if (ce) begin
      cause_q <= valid_end_framing_seen_bad | (rx_msg_ok & ((rx_msg_is_goodcrc & auto_retry_mode)
        | (rx_msg_is_duplicate & auto_response_mode)));
      take_q <= write & ~waitrequest;
    end
  end
  // Answer cycle of a receive status read
  assign rx_rd = read & ~waitrequest & ce & (address == (`PDEV_IDX_RX_STAT << 2));
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  wait_one_a: assert property ((read | write) & waitrequest & ce |=> !waitrequest)
    else $error("waitrequest did not drop one cycle after a request");
  wait_pulse_a: assert property (!waitrequest & ce |=> waitrequest)
    else $error("waitrequest low for more than one cycle");
  reset_vals_a: assert property ($rose(rstn) |-> waitrequest & !rx_event_irq
    & !tx_event_irq & !rx_discard & !auto_retry_mode) else $error("bad value after reset");
  discard_match_a: assert property (rx_discard == cause_q)
    else $error("discard pulse does not follow its cause");
  fifo_live_a: assert property (rx_rd |-> readdata[7] == $past(rx_fifo_has_data))
    else $error("fifo bit does not follow the fifo");
  reserved_zero_a: assert property (rx_rd |-> readdata[31:8] == 24'h0 && !readdata[4])
    else $error("reserved receive bits not zero");
  sop_ctl_hold_a: assert property (!$stable(receive_control_second) |-> take_q)
    else $error("framing enables changed without a write");
  mode_hold_a: assert property (!$stable(auto_retry_mode) |-> take_q)
    else $error("retry mode changed without a write");
  cover property (rx_rd);
  cover property (rx_discard);
  cover property (rx_event_irq);
  cover property (tx_event_irq);
endmodule : pdev_chk
bind pdev_event_status pdev_chk u_chk (
  .clk(clk), .rstn(rstn), .ce(ce), .address(address), .read(read), .write(write),
  .readdata(readdata), .waitrequest(waitrequest), .rx_fifo_has_data(rx_fifo_has_data),
  .valid_end_framing_seen_bad(valid_end_framing_seen_bad), .rx_msg_ok(rx_msg_ok), .rx_msg_is_goodcrc(rx_msg_is_goodcrc),
  .rx_msg_is_duplicate(rx_msg_is_duplicate), .auto_retry_mode(auto_retry_mode),
  .auto_response_mode(auto_response_mode), .receive_control_second(receive_control_second),
  .rx_discard(rx_discard), .rx_event_irq(rx_event_irq), .tx_event_irq(tx_event_irq));
`default_nettype wire

// ### verif/testbench.sv
// Self-checking bench: event rows in one loop, then hand tests.
// Assumes the checker is bound to the design; inputs move on rising edges.
`timescale 1ns/1ns
`default_nettype none
`include "pdev_consts.svh"
module testbench;
  import pdev_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic ce = 1'b1;
  pdev_addr_t address = '0;
  logic read = 1'b0;
  logic write = 1'b0;
  pdev_word_t writedata = '0;
  pdev_word_t readdata;
  logic waitrequest;
  logic [9:0] ev = '0;
  logic [5:0] qual = '0;
  logic fifo = 1'b0;
  logic busy = 1'b0;
  logic irq_tx;
  logic irq_rx;
  logic mode_rty;
  logic mode_rsp;
  logic mode_tmr;
  int bad_count = 0;
  int num_checks = 0;
  pdev_byte_t q;
  // Rows: mode, strobes, {reset signal, goodcrc, duplicate, sop type}, tx and rx expected
  logic [34:0] rows [15] = '{
    {3'h0, 10'h001, 6'h00, 8'h00, 8'h00}, {3'h1, 10'h001, 6'h00, 8'h02, 8'h00},
    {3'h4, 10'h002, 6'h00, 8'h02, 8'h00}, {3'h1, 10'h004, 6'h00, 8'h01, 8'h00},
    {3'h0, 10'h004, 6'h00, 8'h00, 8'h00}, {3'h1, 10'h004, 6'h20, 8'h00, 8'h00},
    {3'h0, 10'h008, 6'h00, 8'h08, 8'h00}, {3'h0, 10'h010, 6'h00, 8'h00, 8'h20},
    {3'h0, 10'h020, 6'h00, 8'h00, 8'h08}, {3'h0, 10'h040, 6'h00, 8'h00, 8'h02},
    {3'h0, 10'h040, 6'h03, 8'h00, 8'h00}, {3'h1, 10'h080, 6'h10, 8'h00, 8'h00},
    {3'h0, 10'h080, 6'h10, 8'h00, 8'h01}, {3'h2, 10'h080, 6'h08, 8'h00, 8'h00},
    {3'h2, 10'h080, 6'h10, 8'h00, 8'h01}};
  // Clock of 100 ns
  always #50 clk = ~clk;
  pdev_event_status dut (
    .clk(clk), .rstn(rstn), .ce(ce), .address(address), .read(read), .write(write),
    .byteenable(4'hF), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .ack_timer_expired(ev[0]), .retry_limit_exceeded(ev[1]), .goodcrc_reply_seen(ev[2]),
    .tx_is_reset_signal(qual[5]), .tx_switched_off(ev[3]), .rx_fifo_has_data(fifo),
    .line_activity_pin(busy), .rx_cable_reset(ev[4]), .rx_hard_reset(ev[5]),
    .valid_start_framing_seen_ok(ev[6]), .valid_end_framing_seen_ok(ev[8]), .valid_end_framing_seen_bad(ev[9]), .valid_start_framing_seen_type(qual[2:0]),
    .rx_msg_ok(ev[7]), .rx_msg_is_goodcrc(qual[4]), .rx_msg_is_duplicate(qual[3]),
    .auto_retry_mode(mode_rty), .auto_response_mode(mode_rsp), .ack_timer_enable(mode_tmr),
    .receive_control_second(), .rx_discard(), .tx_event_irq(irq_tx), .rx_event_irq(irq_rx));
  // Avalon transfer; an edge passes first so strobes never toggle twice in a step
  task automatic bus(input logic wr, input pdev_addr_t idx, input pdev_byte_t d);
    @(posedge clk);
    address <= idx << 2;
    writedata <= {24'h000000, d};
    read <= ~wr;
    write <= wr;
    @(posedge clk);
    while (waitrequest) @(posedge clk);
    q = readdata[7:0];
    read <= 1'b0;
    write <= 1'b0;
  endtask : bus
  task automatic check(input string name, input pdev_byte_t seen, input pdev_byte_t exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h, seen %h", name, exp, seen);
    end
  endtask : check
  task automatic chk_rd(input string name, input pdev_addr_t idx, input pdev_byte_t exp);
    bus(1'b0, idx, 8'h00);
    check(name, q, exp);
  endtask : chk_rd
  // One-cycle strobe pulse
  task automatic pulse(input logic [9:0] e);
    @(posedge clk);
    ev <= e;
    @(posedge clk);
    ev <= '0;
  endtask : pulse
  task automatic summarize;
    if (bad_count == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : summarize
  // Watchdog; the whole sequence needs fewer than four hundred cycles
  initial begin
    repeat (5000) @(posedge clk);
    bad_count++;
    summarize();
  end
  initial begin
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    bus(1'b1, `PDEV_IDX_RX_STAT, 8'h40);
    bus(1'b1, `PDEV_IDX_RX_CTL_SECOND, 8'h01);
    // Ordinary strobes, each cleared by writing ones afterwards
    for (int i = 0; i < 15; i++) begin
      bus(1'b1, `PDEV_IDX_MODE, {5'h00, rows[i][34:32]});
      qual <= rows[i][21:16];
      pulse(rows[i][31:22]);
      // Mode pins are settled two edges after the mode write
      check("mode pins", {5'h00, mode_tmr, mode_rsp, mode_rty}, {5'h00, rows[i][34:32]});
      chk_rd("tx status", `PDEV_IDX_TX_STAT, rows[i][15:8]);
      chk_rd("rx status", `PDEV_IDX_RX_STAT, rows[i][7:0]);
      bus(1'b1, `PDEV_IDX_TX_STAT, 8'hFF);
      bus(1'b1, `PDEV_IDX_RX_STAT, 8'hFF);
    end
    bus(1'b1, `PDEV_IDX_MODE, 8'h00);
    // Zero write keeps a flag; a set on the clearing edge must win
    pulse(10'h080);
    bus(1'b1, `PDEV_IDX_RX_STAT, 8'h00);
    chk_rd("rx kept", `PDEV_IDX_RX_STAT, 8'h01);
    fork
      bus(1'b1, `PDEV_IDX_RX_STAT, 8'h01);
      begin
        repeat (2) @(posedge clk);
        ev <= 10'h080;
        @(posedge clk);
        ev <= '0;
      end
    join
    chk_rd("rx set wins", `PDEV_IDX_RX_STAT, 8'h01);
    bus(1'b1, `PDEV_IDX_RX_STAT, 8'h01);
    chk_rd("rx cleared", `PDEV_IDX_RX_STAT, 8'h00);
    // Fifo bit ignores writes and follows the fifo
    fifo <= 1'b1;
    bus(1'b1, `PDEV_IDX_RX_STAT, 8'h80);
    chk_rd("fifo bit", `PDEV_IDX_RX_STAT, 8'h80);
    fifo <= 1'b0;
    chk_rd("fifo empty", `PDEV_IDX_RX_STAT, 8'h00);
    // Enabled frame, then a disabled frame with a good end followed by a bad delimiter
    qual <= 6'h00;
    pulse(10'h040);
    pulse(10'h100);
    chk_rd("frame on", `PDEV_IDX_RX_STAT, 8'h06);
    bus(1'b1, `PDEV_IDX_RX_STAT, 8'hFF);
    qual <= 6'h03;
    pulse(10'h040);
    pulse(10'h100);
    pulse(10'h200);
    chk_rd("frame off", `PDEV_IDX_RX_STAT, 8'h00);
    // Busy then quiet line; synchroniser needs about four edges
    busy <= 1'b1;
    repeat (6) @(posedge clk);
    busy <= 1'b0;
    repeat (6) @(posedge clk);
    chk_rd("idle event", `PDEV_IDX_RX_STAT, 8'h40);
    bus(1'b1, `PDEV_IDX_RX_STAT, 8'h40);
    bus(1'b1, `PDEV_IDX_RX_EN, 8'h40);
    chk_rd("idle on enable", `PDEV_IDX_RX_STAT, 8'h40);
    check("rx irq", {7'h00, irq_rx}, 8'h01);
    bus(1'b1, `PDEV_IDX_RX_EN, 8'h01);
    repeat (3) @(posedge clk);
    check("rx irq masked", {7'h00, irq_rx}, 8'h00);
    chk_rd("summary masked", `PDEV_IDX_SUMMARY, 8'h00);
    bus(1'b1, `PDEV_IDX_TX_EN, 8'h08);
    pulse(10'h008);
    repeat (3) @(posedge clk);
    check("tx irq", {7'h00, irq_tx}, 8'h01);
    chk_rd("summary tx", `PDEV_IDX_SUMMARY, 8'h01);
    bus(1'b1, 16'h1A8F, 8'hFF);
    chk_rd("unmapped", 16'h1A8F, 8'h00);
    // Second reset in mid-run
    rstn <= 1'b0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    chk_rd("rx reset", `PDEV_IDX_RX_STAT, 8'h40);
    chk_rd("tx reset", `PDEV_IDX_TX_STAT, 8'h00);
    summarize();
  end
endmodule : testbench
`default_nettype wire
